// file: hw/phy_test_pkg.sv
package phy_test_pkg;
    // Phys behind this port and their index width
    localparam int NUM_PHY = 2;
    localparam int PHY_W = 1;
    localparam int PAGE_BYTES = 32;
    localparam int CNT_W = 16;

    // Page codes and header values
    localparam logic [7:0] PG_SUPPORTED = 8'h00;
    localparam logic [7:0] PG_PHY_TEST = 8'h3F;
    localparam logic [3:0] PROTO_SAS = 4'h6;
    localparam logic [15:0] PLEN_SUPPORTED = 16'h0000;
    localparam logic [15:0] PLEN_PHY_TEST = 16'h001C;
    localparam logic [15:0] HDR_BYTES = 16'h0004;

    // Byte positions within a page
    localparam int B_CODE = 0;
    localparam int B_PROTO = 1;
    localparam int B_LEN_HI = 2;
    localparam int B_LEN_LO = 3;
    localparam int B_PHY = 4;
    localparam int B_FUNC = 5;
    localparam int B_PAT = 6;
    localparam int B_MODE = 7;
    localparam int B_RSV_A_LO = 8;
    localparam int B_RSV_A_HI = 10;
    localparam int B_CTRL = 11;
    localparam int B_DW = 12;
    localparam int DW_BYTES = 8;
    localparam int B_RSV_B_LO = 20;
    localparam int B_RSV_B_HI = 31;

    // Fields of the mode byte
    localparam int SATA_BIT = 6;
    localparam int SSC_HI = 5;
    localparam int SSC_LO = 4;
    localparam int RATE_HI = 3;

    // Test functions
    localparam logic [7:0] FN_STOP = 8'h00;
    localparam logic [7:0] FN_START = 8'h01;

    // Pattern codes
    localparam logic [7:0] PAT_JTPAT = 8'h01;
    localparam logic [7:0] PAT_CJTPAT = 8'h02;
    localparam logic [7:0] PAT_TRAIN = 8'h10;
    localparam logic [7:0] PAT_TRAIN_DONE = 8'h11;
    localparam logic [7:0] PAT_IDLE = 8'h12;
    localparam logic [7:0] PAT_SCRAMBLE_0 = 8'h13;
    localparam logic [7:0] PAT_TWO_DWORDS = 8'h40;
    localparam logic [7:0] PAT_PRBS7 = 8'hF0;

    // Link rates
    localparam logic [3:0] RATE_1G5 = 4'h8;
    localparam logic [3:0] RATE_3G0 = 4'h9;
    localparam logic [3:0] RATE_6G0 = 4'hA;
    localparam logic [3:0] RATE_12G = 4'hB;

    // Spread-spectrum codes
    localparam logic [1:0] SSC_NONE = 2'h0;
    localparam logic [1:0] SSC_DOWN = 2'h2;

    // Dword character control
    localparam logic [7:0] CTRL_NONE = 8'h00;
    localparam logic [7:0] CTRL_FIFTH = 8'h08;
    localparam logic [7:0] CTRL_FIRST = 8'h80;
    localparam logic [7:0] CTRL_BOTH = 8'h88;
    localparam int CTRL_FIRST_BIT = 7;
    localparam int CTRL_FIFTH_BIT = 3;
    localparam int K_FIRST_IDX = 0;
    localparam int K_FIFTH_IDX = 4;

    // Register map, byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] A_STATUS = 8'h00;
    localparam logic [7:0] A_MASK = 8'h04;
    localparam logic [7:0] A_PRESENT = 8'h08;
    localparam logic [7:0] A_ACTIVE = 8'h0C;
    localparam logic [7:0] A_RESULT = 8'h10;

    // Event bits of status and mask
    localparam int NUM_EV = 5;
    localparam int EV_ACCEPT = 0;
    localparam int EV_REJECT = 1;
    localparam int EV_START = 2;
    localparam int EV_STOP = 3;
    localparam int EV_ARMED = 4;

    // Reset values
    localparam logic [4:0] MASK_RST = 5'h00;
    localparam logic [1:0] PRESENT_RST = 2'h3;

    typedef enum logic [1:0] {
        RES_GOOD,
        RES_BAD_FIELD,
        RES_BAD_LENGTH
    } result_type;
endpackage

// file: hw/page_byte_capture.sv
module page_byte_capture
    import phy_test_pkg::*;
(
    input wire logic mclk,                                     // Core clock
    input wire logic srst,                                     // Synchronous reset
    input wire logic start,                                    // New command, clears the buffer
    input wire logic byte_valid,                               // Page byte present
    input wire logic [7:0] byte_data,                          // Page byte
    input wire logic byte_last,                                // Final page byte
    output logic [PAGE_BYTES-1:0][7:0] page,                   // Captured page bytes
    output logic [CNT_W-1:0] count,                            // Bytes received
    output logic done                                          // Pulse after the last byte
);
    logic [PAGE_BYTES-1:0][7:0] page_r;
    logic [CNT_W-1:0] count_r;
    logic done_r;

    assign page = page_r;
    assign count = count_r;
    assign done = done_r;

    // Bytes past the page size are counted but dropped; the length check rejects them
    genvar i;
    generate
        for (i = 0; i < PAGE_BYTES; i++) begin : g_byte
            always_ff @(posedge mclk) begin
                if (srst || start) begin
                    page_r[i] <= 8'h00;
                end else if (byte_valid && count_r == CNT_W'(i)) begin
                    page_r[i] <= byte_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge mclk) begin
        if (srst || start) begin
            count_r <= '0;
        end else if (byte_valid && count_r != '1) begin
            count_r <= count_r + 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= byte_valid && byte_last && !start;
        end
    end
endmodule

// file: hw/phy_test_pattern_control.sv
module phy_test_pattern_control
    import phy_test_pkg::*;
(
    input wire logic mclk,                                     // Core clock, 50 MHz
    input wire logic srst,                                     // Synchronous reset
    input wire logic [ADDR_W-1:0] avs_address,                 // Register byte address
    input wire logic avs_read,                                 // Register read
    input wire logic avs_write,                                // Register write
    input wire logic [31:0] avs_writedata,                     // Register write data
    output logic [31:0] avs_readdata,                          // Register read data
    output logic avs_waitrequest,                              // Stall until answered
    output logic irq,                                          // Unmasked event pending
    input wire logic cmd_start,                                // Send-diagnostic data phase begins
    input wire logic [15:0] cmd_param_len,                     // Parameter list length
    input wire logic byte_valid,                               // Page byte present
    input wire logic [7:0] byte_data,                          // Page byte
    input wire logic byte_last,                                // Final page byte
    output logic cmd_done,                                     // Verdict pulse
    output logic cmd_check,                                    // Check condition with cmd_done
    output logic [1:0] cmd_result,                             // Reason, a result_type code
    input wire logic rcv_diag,                                 // Receive-diagnostics command seen
    output logic list_armed,                                   // Supported-page list to be returned
    output logic [NUM_PHY-1:0] test_active,                    // Phy sending a test pattern
    output logic [NUM_PHY-1:0] link_reset,                     // Link reset request pulse
    output logic [NUM_PHY-1:0][7:0] tx_pattern,                // Pattern code per phy
    output logic [NUM_PHY-1:0][3:0] tx_rate,                   // Link rate code per phy
    output logic [NUM_PHY-1:0][1:0] tx_ssc,                    // Spread-spectrum select per phy
    output logic [NUM_PHY-1:0][63:0] tx_dwords,                // Two pattern dwords, first byte low
    output logic [NUM_PHY-1:0][7:0] tx_kchar                   // Bit i marks dword byte i as control
);
    import phy_test_pkg::*;

    logic [PAGE_BYTES-1:0][7:0] page;
    logic [CNT_W-1:0] rx_count;
    logic rx_done;
    logic [15:0] param_len_r;

    page_byte_capture u_capture (
        .mclk(mclk),
        .srst(srst),
        .start(cmd_start),
        .byte_valid(byte_valid),
        .byte_data(byte_data),
        .byte_last(byte_last),
        .page(page),
        .count(rx_count),
        .done(rx_done)
    );

    always_ff @(posedge mclk) begin
        if (srst) begin
            param_len_r <= 16'h0000;
        end else if (cmd_start) begin
            param_len_r <= cmd_param_len;
        end
    end

    // Field decode
    logic [7:0] pg_code;
    logic [15:0] pg_len;
    logic [7:0] func;
    logic [7:0] pat;
    logic [3:0] rate;
    logic [1:0] ssc;
    logic sata;
    logic [7:0] ctrl;
    logic [PHY_W-1:0] phy_sel;
    logic [7:0] kmask;

    assign pg_code = page[B_CODE];
    assign pg_len = {page[B_LEN_HI], page[B_LEN_LO]};
    assign func = page[B_FUNC];
    assign pat = page[B_PAT];
    assign rate = page[B_MODE][RATE_HI:0];
    assign ssc = page[B_MODE][SSC_HI:SSC_LO];
    assign sata = page[B_MODE][SATA_BIT];
    assign ctrl = page[B_CTRL];
    assign phy_sel = page[B_PHY][PHY_W-1:0];

    // Control-character map; index 0 is the first dword byte
    always_comb begin
        kmask = 8'h00;
        kmask[K_FIRST_IDX] = ctrl[CTRL_FIRST_BIT];
        kmask[K_FIFTH_IDX] = ctrl[CTRL_FIFTH_BIT];
    end

    // Verdict, computed from the whole page before anything moves
    logic len_ok;
    logic hdr_ok;
    logic phy_ok;
    logic func_ok;
    logic pat_ok;
    logic rate_ok;
    logic ssc_ok;
    logic ctrl_ok;
    logic rsv_ok;
    logic is_list;
    logic is_test;
    result_type verdict;
    logic [NUM_PHY-1:0] present_r;

    always_comb begin
        is_list = pg_code == PG_SUPPORTED;
        is_test = pg_code == PG_PHY_TEST;
        len_ok = 1'b0;
        if (is_list) begin
            len_ok = pg_len == PLEN_SUPPORTED && param_len_r == PLEN_SUPPORTED + HDR_BYTES;
        end else if (is_test) begin
            len_ok = pg_len == PLEN_PHY_TEST && param_len_r == PLEN_PHY_TEST + HDR_BYTES;
        end
        len_ok = len_ok && rx_count == param_len_r;
        hdr_ok = page[B_PROTO][3:0] == PROTO_SAS;
        phy_ok = page[B_PHY] < 8'(NUM_PHY) && present_r[phy_sel];
        func_ok = func == FN_STOP || func == FN_START;
        unique case (pat)
            PAT_JTPAT, PAT_CJTPAT, PAT_TRAIN, PAT_TRAIN_DONE,
            PAT_IDLE, PAT_SCRAMBLE_0, PAT_TWO_DWORDS, PAT_PRBS7: pat_ok = 1'b1;
            default: pat_ok = 1'b0;
        endcase
        rate_ok = rate >= RATE_1G5 && rate <= RATE_12G;
        ssc_ok = ssc == SSC_NONE || ssc == SSC_DOWN;
        unique case (ctrl)
            CTRL_NONE, CTRL_FIFTH, CTRL_FIRST, CTRL_BOTH: ctrl_ok = 1'b1;
            default: ctrl_ok = 1'b0;
        endcase
        rsv_ok = 1'b1;
        for (int b = B_RSV_A_LO; b <= B_RSV_A_HI; b++) begin
            rsv_ok = rsv_ok && page[b] == 8'h00;
        end
        for (int b = B_RSV_B_LO; b <= B_RSV_B_HI; b++) begin
            rsv_ok = rsv_ok && page[b] == 8'h00;
        end
        if (!len_ok) begin
            verdict = RES_BAD_LENGTH;
        end else if (is_list) begin
            verdict = RES_GOOD;
        end else if (!hdr_ok || !phy_ok || !func_ok || !rsv_ok) begin
            verdict = RES_BAD_FIELD;
        end else if (func == FN_START && (!pat_ok || !rate_ok || sata || !ssc_ok || !ctrl_ok)) begin
            verdict = RES_BAD_FIELD;
        end else begin
            verdict = RES_GOOD;
        end
    end

    // Stage the verdict; phys only move one cycle later, off the staged copy
    logic apply_r;
    result_type verdict_r;
    logic list_r;
    logic start_r;
    logic stop_r;
    logic [PHY_W-1:0] sel_r;

    always_ff @(posedge mclk) begin
        if (srst) begin
            apply_r <= 1'b0;
            verdict_r <= RES_GOOD;
            list_r <= 1'b0;
            start_r <= 1'b0;
            stop_r <= 1'b0;
            sel_r <= '0;
        end else begin
            apply_r <= rx_done;
            if (rx_done) begin
                verdict_r <= verdict;
                list_r <= is_list;
                start_r <= is_test && func == FN_START;
                stop_r <= is_test && func == FN_STOP;
                sel_r <= phy_sel;
            end
        end
    end

    logic accept;
    assign accept = apply_r && verdict_r == RES_GOOD;

    always_ff @(posedge mclk) begin
        if (srst) begin
            cmd_done <= 1'b0;
            cmd_check <= 1'b0;
            cmd_result <= 2'h0;
        end else begin
            cmd_done <= apply_r;
            cmd_check <= apply_r && verdict_r != RES_GOOD;
            if (apply_r) begin
                cmd_result <= verdict_r;
            end
        end
    end

    // Armed until the next receive-diagnostics command; a new arm wins
    always_ff @(posedge mclk) begin
        if (srst) begin
            list_armed <= 1'b0;
        end else if (accept && list_r) begin
            list_armed <= 1'b1;
        end else if (rcv_diag) begin
            list_armed <= 1'b0;
        end
    end

    // Per-phy test state; page fields still hold the accepted page here
    logic [NUM_PHY-1:0] started;
    logic [NUM_PHY-1:0] stopped;

    genvar p;
    generate
        for (p = 0; p < NUM_PHY; p++) begin : g_phy
            logic hit;
            assign hit = accept && sel_r == PHY_W'(p);
            assign started[p] = hit && start_r && !test_active[p];
            assign stopped[p] = hit && stop_r && test_active[p];

            always_ff @(posedge mclk) begin
                if (srst) begin
                    test_active[p] <= 1'b0;
                    link_reset[p] <= 1'b0;
                end else begin
                    link_reset[p] <= stopped[p];
                    if (started[p]) begin
                        test_active[p] <= 1'b1;
                    end else if (stopped[p]) begin
                        test_active[p] <= 1'b0;
                    end
                end
            end

            // A running phy keeps its settings; a second start is ignored
            always_ff @(posedge mclk) begin
                if (srst) begin
                    tx_pattern[p] <= 8'h00;
                    tx_rate[p] <= 4'h0;
                    tx_ssc[p] <= 2'h0;
                    tx_dwords[p] <= 64'h0;
                    tx_kchar[p] <= 8'h00;
                end else if (started[p]) begin
                    tx_pattern[p] <= pat;
                    tx_rate[p] <= rate;
                    tx_ssc[p] <= ssc;
                    tx_dwords[p] <= page[B_DW +: DW_BYTES];
                    tx_kchar[p] <= kmask;
                end
            end
        end
    endgenerate

    // Events, status, mask and interrupt
    logic [NUM_EV-1:0] ev;
    logic [NUM_EV-1:0] status_r;
    logic [NUM_EV-1:0] mask_r;
    logic wr_go;
    logic rd_go;

    always_comb begin
        ev = '0;
        ev[EV_ACCEPT] = accept;
        ev[EV_REJECT] = apply_r && verdict_r != RES_GOOD;
        ev[EV_START] = |started;
        ev[EV_STOP] = |stopped;
        ev[EV_ARMED] = accept && list_r;
    end

    assign wr_go = avs_write && !avs_waitrequest;
    assign rd_go = avs_read && avs_waitrequest;

    // Set wins over a write-one clear in the same cycle
    always_ff @(posedge mclk) begin
        if (srst) begin
            status_r <= '0;
        end else if (wr_go && avs_address == A_STATUS) begin
            status_r <= (status_r & ~avs_writedata[NUM_EV-1:0]) | ev;
        end else begin
            status_r <= status_r | ev;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            mask_r <= MASK_RST;
            present_r <= PRESENT_RST;
        end else if (wr_go) begin
            if (avs_address == A_MASK) begin
                mask_r <= avs_writedata[NUM_EV-1:0];
            end
            if (avs_address == A_PRESENT) begin
                present_r <= avs_writedata[NUM_PHY-1:0];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_r & mask_r);
        end
    end

    // One wait cycle per access: the answer edge is the second edge of the request
    always_ff @(posedge mclk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            avs_readdata <= 32'h0;
        end else if (rd_go) begin
            unique case (avs_address)
                A_STATUS: avs_readdata <= 32'(status_r);
                A_MASK: avs_readdata <= 32'(mask_r);
                A_PRESENT: avs_readdata <= 32'(present_r);
                A_ACTIVE: avs_readdata <= 32'(test_active);
                A_RESULT: avs_readdata <= 32'({list_armed, cmd_result});
                default: avs_readdata <= 32'h0;
            endcase
        end
    end
endmodule

// file: tb/phy_test_pattern_control_sva.sv
module phy_test_pattern_control_sva
    import phy_test_pkg::*;
(
    input wire logic mclk, // Clock
    input wire logic srst, // Reset
    input wire logic avs_read, // Read
    input wire logic avs_write, // Write
    input wire logic avs_waitrequest, // Stall
    input wire logic byte_last, // Last byte
    input wire logic rcv_diag, // Receive seen
    input wire logic cmd_done, // Verdict
    input wire logic cmd_check, // Rejected
    input wire logic list_armed, // List armed
    input wire logic [NUM_PHY-1:0] test_active, // Testing
    input wire logic [NUM_PHY-1:0] link_reset, // Link reset
    input wire logic [NUM_PHY-1:0][3:0] tx_rate, // Rate
    input wire logic [NUM_PHY-1:0][7:0] tx_kchar // Control marks
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (srst);
    property p_wait_one; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("bus answer late");
    property p_verdict_lat; byte_last |-> ##3 cmd_done; endproperty
    a_verdict_lat: assert property (p_verdict_lat) else $error("verdict late");
    property p_done_pulse; cmd_done |=> !cmd_done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("verdict too long");
    property p_reject_still; cmd_check |-> cmd_done && $stable(test_active) && link_reset == '0; endproperty
    a_reject_still: assert property (p_reject_still) else $error("rejected page changed a phy");
    property p_start_cause; (test_active & ~$past(test_active)) != '0 |-> cmd_done && !cmd_check; endproperty
    a_start_cause: assert property (p_start_cause) else $error("test started without verdict");
    property p_stop_reset;
        !$past(srst) && (~test_active & $past(test_active)) != '0 |-> link_reset == ($past(test_active) & ~test_active);
    endproperty
    a_stop_reset: assert property (p_stop_reset) else $error("stop without link reset");
    property p_arm_cause; $rose(list_armed) |-> cmd_done && !cmd_check; endproperty
    a_arm_cause: assert property (p_arm_cause) else $error("list armed without verdict");
    property p_disarm; rcv_diag |=> !list_armed || cmd_done; endproperty
    a_disarm: assert property (p_disarm) else $error("list stays armed");
    property p_active_legal; test_active[0] |-> tx_rate[0] inside {[4'h8:4'hB]} && (tx_kchar[0] & 8'hEE) == 8'h00; endproperty
    a_active_legal: assert property (p_active_legal) else $error("illegal rate or marks");
    c_reject: cover property (cmd_check);
    c_link_reset: cover property (link_reset != '0);
    c_armed: cover property ($rose(list_armed));
endmodule

bind phy_test_pattern_control phy_test_pattern_control_sva phy_test_pattern_control_sva_inst (
    .mclk(mclk), .srst(srst), .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .byte_last(byte_last), .rcv_diag(rcv_diag), .cmd_done(cmd_done), .cmd_check(cmd_check),
    .list_armed(list_armed), .test_active(test_active), .link_reset(link_reset), .tx_rate(tx_rate),
    .tx_kchar(tx_kchar));

// file: tb/page_host.sv
module page_host (
    input wire logic mclk, // Clock
    output logic cmd_start, // New command
    output logic [15:0] cmd_param_len, // Parameter length
    output logic byte_valid, // Byte strobe
    output logic [7:0] byte_data, // Byte
    output logic byte_last // Last byte
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pg [32];
    logic slow = 1'b0;
    initial {cmd_start, cmd_param_len, byte_valid, byte_data, byte_last} = '0;
    task automatic send(input logic [15:0] len, input int n);
        @(posedge mclk);
        {cmd_start, cmd_param_len} <= {1'b1, len};
        @(posedge mclk);
        cmd_start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            {byte_valid, byte_data, byte_last} <= {1'b1, pg[i], i == n - 1};
            @(posedge mclk);
            if (slow && i < n - 1) begin
                {byte_valid, byte_data} <= {1'b0, ~pg[i]};
                @(posedge mclk);
            end
        end
        // A released data line must not keep showing the last byte
        {byte_valid, byte_data, byte_last} <= {1'b0, ~pg[n - 1], 1'b0};
    endtask
    task automatic phy_page(input logic [39:0] f, input logic [63:0] dw);
        pg = '{default: 8'h00};
        {pg[0], pg[1], pg[3]} = {8'h3F, 8'h06, 8'h1C};
        {pg[4], pg[5], pg[6], pg[7], pg[11]} = f;
        for (int i = 0; i < 8; i++) pg[12 + i] = dw[8 * i +: 8];
        send(16'h0020, 32);
    endtask
endmodule

// file: tb/phy_test_pattern_control_tb.sv
module phy_test_pattern_control_tb import phy_test_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] DW = 64'h8877665544332211;
    logic mclk = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, rcv_diag = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
    logic avs_waitrequest, irq, cmd_start, byte_valid, byte_last, cmd_done, cmd_check, list_armed;
    logic [15:0] cmd_param_len;
    logic [7:0] byte_data;
    logic [1:0] cmd_result;
    logic [NUM_PHY-1:0] test_active, link_reset;
    logic [NUM_PHY-1:0][7:0] tx_pattern, tx_kchar;
    logic [NUM_PHY-1:0][3:0] tx_rate;
    logic [NUM_PHY-1:0][1:0] tx_ssc;
    logic [NUM_PHY-1:0][63:0] tx_dwords;
    logic [39:0] bad [12] = '{40'h0201010800, 40'h0102010800, 40'h01FF010800, 40'h0101000800, 40'h0101030800,
        40'h0101410800, 40'h0101010700, 40'h0101010C00, 40'h0101014800, 40'h0101011800, 40'h0101013800,
        40'h0101010801};
    logic [7:0] pats [8] = '{8'h01, 8'h02, 8'h10, 8'h11, 8'h12, 8'h13, 8'h40, 8'hF0};
    logic [7:0] ctrls [4] = '{8'h00, 8'h08, 8'h80, 8'h88};
    int failures = 0, tests_run = 0, cycles = 0;
    always #10 mclk = ~mclk;
    phy_test_pattern_control phy_test_pattern_control_inst (.mclk(mclk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .irq(irq), .cmd_start(cmd_start), .cmd_param_len(cmd_param_len),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last), .cmd_done(cmd_done),
        .cmd_check(cmd_check), .cmd_result(cmd_result), .rcv_diag(rcv_diag), .list_armed(list_armed),
        .test_active(test_active), .link_reset(link_reset), .tx_pattern(tx_pattern), .tx_rate(tx_rate),
        .tx_ssc(tx_ssc), .tx_dwords(tx_dwords), .tx_kchar(tx_kchar));
    page_host page_host_inst (.mclk(mclk), .cmd_start(cmd_start), .cmd_param_len(cmd_param_len),
        .byte_valid(byte_valid), .byte_data(byte_data), .byte_last(byte_last));
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, wr, !wr};
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        {avs_write, avs_read} <= 2'b00;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        chk(name, q, exp);
    endtask
    task automatic verdict(input logic c, input logic [1:0] r);
        repeat (8) if (cmd_done !== 1'b1) begin
            @(posedge mclk);
            #1;
        end
        chk("done", cmd_done, 1'b1);
        chk("check", cmd_check, c);
        chk("result", cmd_result, r);
    endtask
    task automatic run(input logic [39:0] f, input logic [63:0] dw, input logic c, input logic [1:0] r);
        page_host_inst.phy_page(f, dw);
        verdict(c, r);
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rd(A_MASK, 32'h0, "mask");
        rd(A_PRESENT, 32'h3, "present");
        bus(1'b1, 8'h40, 32'hFFFFFFFF);
        rd(8'h40, 32'h0, "unmapped");
        bus(1'b1, A_MASK, 32'h1F);
        page_host_inst.pg = '{default: 8'h00};
        page_host_inst.send(16'h0004, 4);
        verdict(1'b0, 2'h0);
        chk("armed", list_armed, 1'b1);
        @(posedge mclk);
        rcv_diag <= 1'b1;
        @(posedge mclk);
        rcv_diag <= 1'b0;
        @(posedge mclk);
        #1 chk("armed", list_armed, 1'b0);
        run(40'h0001402A88, DW, 1'b0, 2'h0);
        chk("active", test_active, 2'b01);
        chk("dwords", tx_dwords[0], DW);
        chk("kchar", tx_kchar[0], 8'h11);
        chk("ssc", tx_ssc[0], 2'h2);
        chk("rate", tx_rate[0], 4'hA);
        @(posedge mclk);
        #1 chk("irq", irq, 1'b1);
        rd(A_STATUS, 32'h15, "status");
        bus(1'b1, A_STATUS, 32'h1F);
        bus(1'b1, A_MASK, 32'h0);
        for (int i = 0; i < 12; i++) begin
            run(bad[i], DW, 1'b1, 2'h1);
            chk("active", test_active, 2'b01);
        end
        chk("irq", irq, 1'b0);
        rd(A_STATUS, 32'h2, "status");
        rd(A_RESULT, 32'h1, "result");
        rd(A_ACTIVE, 32'h1, "active");
        bus(1'b1, A_MASK, 32'h2);
        @(posedge mclk);
        #1 chk("irq", irq, 1'b1);
        bus(1'b1, A_STATUS, 32'h1F);
        @(posedge mclk);
        #1 chk("irq", irq, 1'b0);
        bus(1'b1, A_PRESENT, 32'h1);
        run(40'h0101010800, DW, 1'b1, 2'h1);
        bus(1'b1, A_PRESENT, 32'h3);
        for (int i = 0; i < 8; i++) begin
            page_host_inst.slow = i[0];
            run({16'h0101, pats[i], 2'b00, i[0], 1'b0, 2'b10, i[1:0], ctrls[i % 4]}, DW, 1'b0, 2'h0);
            chk("pattern", tx_pattern[1], pats[i]);
            chk("rate", tx_rate[1], {2'b10, i[1:0]});
            chk("kchar", tx_kchar[1], {3'b0, ctrls[i % 4][3], 3'b0, ctrls[i % 4][7]});
            run(40'h0100000000, DW, 1'b0, 2'h0);
            chk("linkreset", link_reset, 2'b10);
            chk("active", test_active, 2'b01);
        end
        page_host_inst.slow = 1'b0;
        run(40'h0100000000, DW, 1'b0, 2'h0);
        chk("linkreset", link_reset, 2'b00);
        page_host_inst.send(16'h001F, 32);
        verdict(1'b1, 2'h2);
        run(40'h0001010800, DW, 1'b0, 2'h0);
        chk("pattern", tx_pattern[0], 8'h40);
        run(40'h0000000000, DW, 1'b0, 2'h0);
        chk("linkreset", link_reset, 2'b01);
        chk("active", test_active, 2'b00);
        conclude();
    end
endmodule
